// ==== dv/pdr_host_model.sv ====
// host model issuing single register accesses to the bank
// assumes requests are taken on the rising edge of core_clk_i
`timescale 1ns/1ps
// ============================================================
// host
module pdr_host_model (
    // clock
    input wire logic core_clk_i,
    // requests
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [15:0] reg_wdata_o,
    // answers
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    input wire logic reg_err_i
);
    // idle bus at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end
    // one request held over one taking edge; idle address and write data are inverted so
    // a design that samples them late sees wrong values, not stale ones
    task automatic access(input logic w, input logic [7:0] a,
            input logic [15:0] wd, output logic [15:0] d,
            output logic v, output logic e);
        @(negedge core_clk_i);
        reg_addr_o = a;
        reg_wdata_o = wd;
        reg_wr_o = w;
        reg_rd_o = !w;
        @(negedge core_clk_i);
        d = reg_rdata_i;
        v = reg_rvalid_i;
        e = reg_err_i;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~wd;
    endtask
endmodule // pdr_host_model

// ==== dv/pdr_regs_asserts.sv ====
// port checker for the data register bank, attached by bind
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/1ps
// ============================================================
// checker
module pdr_regs_chk
    import pdr_pkg::*;
#(
    parameter int NUM_PORTS = PDR_NUM_PORTS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic reg_err_o,
    // modes, samples and codes
    input wire logic [NUM_PORTS*4-1:0] port_function_select_i,
    input wire logic conv_valid_i,
    input wire logic [3:0] conv_port_i,
    input wire logic [11:0] conv_raw_i,
    input wire logic [NUM_PORTS*12-1:0] dac_code_o
);
    // index decode; the slices are only trusted when the index is mapped
    wire logic [3:0] idx = reg_addr_i[3:0];
    wire logic code_sel = idx < 4'hC && reg_addr_i[7:4] == 4'h6;
    wire logic res_sel = idx < 4'hC && reg_addr_i[7:4] == 4'h4;
    wire logic [3:0] fn = port_function_select_i[4*idx +: 4];
    wire logic [11:0] cur = dac_code_o[12*idx +: 12];
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered next cycle");
    a_quiet_answer: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without read");
    a_upper_zero: assert property (reg_rvalid_o |->
        !reg_rdata_o[15:12])
        else $error("upper read bits not zero");
    a_err_map: assert property (1'b1 |=> reg_err_o ==
        $past((reg_rd_i || reg_wr_i) && !(code_sel || res_sel)))
        else $error("error flag wrong");
    a_code_write: assert property (reg_wr_i && code_sel |=>
        dac_code_o[12*$past(idx) +: 12] == $past(reg_wdata_i[11:0]))
        else $error("code not stored");
    a_code_hold: assert property (!(reg_wr_i && code_sel) |=>
        $stable(dac_code_o))
        else $error("code changed without write");
    a_code_read: assert property (reg_rd_i && code_sel |=>
        reg_rdata_o[11:0] == $past(cur))
        else $error("code read back wrong");
    a_neg_zero: assert property (reg_rd_i && res_sel &&
        (fn == 4'h9 || fn == 4'hA) |=> reg_rdata_o == 16'h0000)
        else $error("negative input result not zero");
endmodule // pdr_regs_chk

bind pdr_data_regs pdr_regs_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .reg_err_o(reg_err_o), .port_function_select_i(port_function_select_i),
    .conv_valid_i(conv_valid_i), .conv_port_i(conv_port_i),
    .conv_raw_i(conv_raw_i), .dac_code_o(dac_code_o));

// ==== dv/tb_port_adc_dac_data_registers.sv ====
// self-checking bench for the data register bank
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
// ============================================================
// bench
module tb_port_adc_dac_data_registers
    import pdr_pkg::*;
;
    logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_err_o;
    logic [7:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic [47:0] port_function_select_i;
    logic conv_valid_i;
    logic [3:0] conv_port_i;
    logic [11:0] conv_raw_i;
    logic [143:0] dac_code_o;
    int num_errors = 0;
    int check_count = 0;

    pdr_data_regs uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .reg_err_o(reg_err_o),
        .port_function_select_i(port_function_select_i),
        .conv_valid_i(conv_valid_i), .conv_port_i(conv_port_i),
        .conv_raw_i(conv_raw_i), .dac_code_o(dac_code_o));
    pdr_host_model host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i),
        .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
        .reg_err_i(reg_err_o));

    // 100 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // compare one word
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // access and judge data (reads only) and the {valid, error} flags
    task automatic acc(input logic w, input logic [7:0] a,
            input logic [15:0] wd, input logic [15:0] xd,
            input logic [1:0] xf);
        logic [15:0] d;
        logic v, e;
        host.access(w, a, wd, d, v, e);
        if (!w) chk(d, xd);
        chk({14'h0, v, e}, {14'h0, xf});
    endtask
    // one converter sample; raw data inverted when idle
    task automatic conv(input logic [3:0] p, input logic [11:0] r);
        @(negedge core_clk_i);
        conv_valid_i = 1'b1;
        conv_port_i = p;
        conv_raw_i = r;
        @(negedge core_clk_i);
        conv_valid_i = 1'b0;
        conv_raw_i = ~r;
    endtask
    // codes: reset value, write with junk above bit 11, port and read back
    task automatic t_codes;
        logic [11:0] val;
        for (int i = 0; i < PDR_NUM_PORTS; i++) begin
            val = 12'hFFF - 12'(i * 12'h111);
            acc(1'b0, 8'h60 + 8'(i), 16'h0, 16'h0000, 2'b10);
            acc(1'b1, 8'h60 + 8'(i), {4'hF, val}, 16'h0, 2'b00);
            chk({4'h0, dac_code_o[12*i +: 12]}, {4'h0, val});
            acc(1'b0, 8'h60 + 8'(i), 16'h0, {4'h0, val}, 2'b10);
        end
    endtask
    // results per mode 6,7,8,9,10 on ports 0..4, port 5 mode 5 drops
    task automatic t_results;
        logic [11:0] raw [6] = '{12'h900, 12'h3FF, 12'h900, 12'h9AB,
            12'hABC, 12'h123};
        logic [11:0] want [6] = '{12'h900, 12'h3FF, 12'h100, 12'h000,
            12'h000, 12'h000};
        logic [11:0] exp;
        port_function_select_i = {28'h5555555, 20'hA9876};
        for (int i = 0; i < 6; i++) conv(4'(i), raw[i]);
        conv(4'hC, 12'h777);
        for (int i = 0; i < PDR_NUM_PORTS; i++) begin
            exp = (i < 6) ? want[i] : 12'h000;
            acc(1'b0, 8'h40 + 8'(i), 16'h0, {4'h0, exp}, 2'b10);
        end
    endtask
    // read-only results, unmapped indices, mode change to negative input
    task automatic t_protect;
        acc(1'b1, 8'h40, 16'hFFFF, 16'h0, 2'b00);
        acc(1'b0, 8'h40, 16'h0, 16'h0900, 2'b10);
        acc(1'b0, 8'h4C, 16'h0, 16'h0000, 2'b11);
        acc(1'b1, 8'h6C, 16'h0123, 16'h0, 2'b01);
        port_function_select_i[3:0] = 4'h9;
        acc(1'b0, 8'h40, 16'h0, 16'h0000, 2'b10);
        // back to a plain input: the zero stored while negative remains
        port_function_select_i[15:12] = 4'h7;
        acc(1'b0, 8'h43, 16'h0, 16'h0000, 2'b10);
        // below mid scale in mode 8 gives a negative code
        conv(4'h2, 12'h123);
        acc(1'b0, 8'h42, 16'h0, 16'h0923, 2'b10);
    endtask
    // mid-run reset clears codes, results and answer flags
    task automatic t_reset;
        acc(1'b1, 8'h61, 16'h0ABC, 16'h0, 2'b00);
        chk({4'h0, dac_code_o[23:12]}, 16'h0ABC);
        @(negedge core_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        chk({4'h0, dac_code_o[23:12]}, 16'h0000);
        chk({14'h0, reg_rvalid_o, reg_err_o}, 16'h0000);
        rst_i = 1'b0;
        acc(1'b0, 8'h61, 16'h0, 16'h0000, 2'b10);
        acc(1'b0, 8'h41, 16'h0, 16'h0000, 2'b10);
    endtask
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst_i = 1'b1;
        port_function_select_i = '0;
        conv_valid_i = 1'b0;
        conv_port_i = 4'h0;
        conv_raw_i = 12'h000;
        repeat (4) @(negedge core_clk_i);
        rst_i = 1'b0;
        t_codes();
        t_results();
        t_protect();
        t_reset();
        test_done();
    end
    // watchdog: the run needs well under 1000 cycles
    initial begin
        #50000;
        num_errors++;
        test_done();
    end
endmodule // tb_port_adc_dac_data_registers

// ==== include/pdr_pkg.sv ====
// ============================================================
// per-port conversion data register bank: shared constants
// ============================================================
// holds the register index map, field layout, function codes and
// reset values; assumes the serial front end decodes an 8-bit index.
package pdr_pkg;

    // ========================================================
    // geometry
    // ========================================================
    localparam int PDR_NUM_PORTS = 12;
    localparam int PDR_DATA_W = 12;
    localparam int PDR_REG_W = 16;
    localparam int PDR_ADDR_W = 8;
    localparam int PDR_PORT_W = 4;
    localparam int PDR_FUNC_W = 4;

    // ========================================================
    // register index map (one 16-bit register per index)
    // ========================================================
    localparam logic [7:0] PDR_RESULT_BASE = 8'h40;
    localparam logic [7:0] PDR_CODE_BASE = 8'h60;

    // ========================================================
    // field layout and reset values
    // ========================================================
    localparam int PDR_DATA_LSB = 0;
    localparam int PDR_DATA_MSB = 11;
    localparam int PDR_FUNC_LSB = 12;
    localparam int PDR_FUNC_MSB = 15;
    localparam logic [11:0] PDR_RESULT_RST = 12'h000;
    localparam logic [11:0] PDR_CODE_RST = 12'h000;
    localparam logic [11:0] PDR_ZERO_DATA = 12'h000;
    localparam logic [15:0] PDR_READ_ZERO = 16'h0000;

    // ========================================================
    // port function select codes
    // ========================================================
    localparam logic [3:0] PDR_FN_DAC_MON = 4'h6;
    localparam logic [3:0] PDR_FN_SE_IN = 4'h7;
    localparam logic [3:0] PDR_FN_DIFF_POS = 4'h8;
    localparam logic [3:0] PDR_FN_DIFF_NEG = 4'h9;
    localparam logic [3:0] PDR_FN_PSEUDO_NEG = 4'hA;

    // negative converter input: its own result always reads zero
    function automatic logic pdr_is_neg_input(input logic [3:0] fn);
        return (fn == PDR_FN_DIFF_NEG) || (fn == PDR_FN_PSEUDO_NEG);
    endfunction

endpackage

// ==== rtl/pdr_data_regs.sv ====
// ============================================================
// per-port conversion data register bank
// ============================================================
// holds one result and one output code per port behind an indexed
// register port; assumes the serial front end, the port configuration
// logic and the converter sequencer all run on core_clk_i.
`timescale 1ns/1ps
module pdr_data_regs
    import pdr_pkg::*;
#(
    parameter int NUM_PORTS = PDR_NUM_PORTS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register access from the serial front end
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_err_o,
    // function field of every port configuration, port 0 lowest
    input wire logic [NUM_PORTS*4-1:0] port_function_select_i,
    // converter sample delivery
    input wire logic conv_valid_i,
    input wire logic [3:0] conv_port_i,
    input wire logic [11:0] conv_raw_i,
    // output codes to the converter drivers, port 0 lowest
    output logic [NUM_PORTS*12-1:0] dac_code_o
);

    // ========================================================
    // index decode
    // ========================================================
    // wrapping subtraction keeps the window test to one compare; the low
    // nibble alone would alias the unused indices onto real ports
    function automatic logic in_window(input logic [7:0] addr,
                                       input logic [7:0] base);
        logic [7:0] off;
        off = addr - base;
        return off < 8'(NUM_PORTS);
    endfunction

    function automatic logic [3:0] port_of(input logic [7:0] addr,
                                           input logic [7:0] base);
        logic [7:0] off;
        off = addr - base;
        return off[3:0];
    endfunction

    // ========================================================
    // storage
    // ========================================================
    // plain flip-flops: twelve words of each kind do not justify a
    // memory, and every code must reach its output stage at once
    logic [11:0] result_q [NUM_PORTS];
    logic [11:0] result_d [NUM_PORTS];
    logic [11:0] code_q [NUM_PORTS];
    logic [11:0] code_d [NUM_PORTS];
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic err_q;
    logic err_d;

    // ========================================================
    // decode of the current access
    // ========================================================
    logic hit_result;
    logic hit_code;
    logic [3:0] acc_port;
    logic [3:0] conv_func;
    logic [11:0] enc_code;
    logic enc_store;
    logic conv_in_range;

    assign hit_result = in_window(reg_addr_i, PDR_RESULT_BASE);
    assign hit_code = in_window(reg_addr_i, PDR_CODE_BASE);
    // the two windows never overlap, so one index serves both kinds
    assign acc_port = hit_result ? port_of(reg_addr_i, PDR_RESULT_BASE)
                                 : port_of(reg_addr_i, PDR_CODE_BASE);
    // out-of-range sample ports are dropped, not wrapped, so a sequencer
    // fault cannot overwrite a neighbouring port
    assign conv_in_range = conv_port_i < 4'(NUM_PORTS);

    // mode of the port the sample belongs to
    always_comb begin
        conv_func = 4'h0;
        if (conv_in_range) begin
            conv_func = port_function_select_i[conv_port_i*4 +: 4];
        end
    end

    // ========================================================
    // sample encoding
    // ========================================================
    pdr_result_encode u_encode (
        .func_i(conv_func),
        .raw_i(conv_raw_i),
        .code_o(enc_code),
        .store_o(enc_store)
    );

    // ========================================================
    // result registers: written only by the converter
    // ========================================================
    // host writes never reach this path, so a stray write cannot
    // corrupt a measurement that software is about to read
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            result_d[i] = result_q[i];
        end
        if (conv_valid_i && conv_in_range && enc_store) begin
            result_d[conv_port_i] = enc_code;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                result_q[i] <= PDR_RESULT_RST;
            end
        end else begin
            result_q <= result_d;
        end
    end

    // ========================================================
    // output-code registers: written only by the host
    // ========================================================
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            code_d[i] = code_q[i];
        end
        if (reg_wr_i && hit_code) begin
            // upper bits of the write word are dropped
            code_d[acc_port] =
                reg_wdata_i[PDR_DATA_MSB:PDR_DATA_LSB];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                code_q[i] <= PDR_CODE_RST;
            end
        end else begin
            code_q <= code_d;
        end
    end

    // codes leave unchanged: the drivers treat them as unsigned
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            dac_code_o[i*12 +: 12] = code_q[i];
        end
    end

    // ========================================================
    // read path and access error
    // ========================================================
    // a read returns the value before any write in the same cycle
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        err_d = 1'b0;
        if (reg_rd_i) begin
            rvalid_d = 1'b1;
            rdata_d = PDR_READ_ZERO;
            if (hit_result) begin
                // a port switched to a negative input reads zero at
                // once, without waiting for its next sample
                if (!pdr_is_neg_input(
                        port_function_select_i[acc_port*4 +: 4])) begin
                    rdata_d = {4'h0, result_q[acc_port]};
                end
            end else if (hit_code) begin
                rdata_d = {4'h0, code_q[acc_port]};
            end else begin
                err_d = 1'b1;
            end
        end
        // result writes are dropped silently, unmapped ones flagged;
        // the error pulse shares the answer slot, so the front end can
        // report it in the frame that carries the data
        if (reg_wr_i && !hit_code && !hit_result) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= PDR_READ_ZERO;
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            err_q <= err_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign reg_err_o = err_q;

endmodule // pdr_data_regs

// ==== rtl/pdr_result_encode.sv ====
// ============================================================
// converter sample encoder
// ============================================================
// turns a raw offset-binary sample into the stored result code for
// the function mode of the sampled port; purely combinational.
`timescale 1ns/1ps
module pdr_result_encode
    import pdr_pkg::*;
(
    // mode of the sampled port
    input wire logic [3:0] func_i,
    // raw sample, offset binary from the converter
    input wire logic [11:0] raw_i,
    // encoded result and whether the mode takes a result at all
    output logic [11:0] code_o,
    output logic store_o
);

    // ========================================================
    // encoding by function mode
    // ========================================================
    // non-converter modes leave the stored result untouched
    always_comb begin
        code_o = raw_i;
        store_o = 1'b0;
        case (func_i)
            PDR_FN_DAC_MON, PDR_FN_SE_IN: begin
                code_o = raw_i;
                store_o = 1'b1;
            end
            PDR_FN_DIFF_POS: begin
                // msb flip maps offset binary onto two's complement
                code_o = {~raw_i[11], raw_i[10:0]};
                store_o = 1'b1;
            end
            PDR_FN_DIFF_NEG, PDR_FN_PSEUDO_NEG: begin
                code_o = PDR_ZERO_DATA;
                store_o = 1'b1;
            end
            default: begin
                code_o = raw_i;
                store_o = 1'b0;
            end
        endcase
    end

endmodule // pdr_result_encode
